// ==== include/sfc_defines.vh ====
// Purpose: constants of the status and control word block
// Assumes: plain Verilog-2005, included by bare name
// Notes: byte offsets of the axi4-lite register map, flag positions, op codes
// Operation
// [RQ1] instruction pointer holds next instruction offset; with code selector forms program counter
// [RQ2] status word has eleven flag fields; six status flags follow alu results
// [RQ3] dedicated ops clear, set or invert the carry flag
// [RQ4] carry shows carry or borrow out of byte or word msb; shifts use it
// [RQ5] zero flag set when result is zero, cleared otherwise
// [RQ6] sign flag is one for negative result, zero for positive
// [RQ7] overflow set when carry into msb differs from carry out
// [RQ8] parity flag is xor of low eight result bits: odd gives one
// [RQ9] aux carry captures carry or borrow at the low four-bit digit
// [RQ10] external maskable interrupts accepted only while interrupt enable is set
// [RQ11] trap flag set raises debug trap after each completed instruction
// [RQ12] string ops increment index when direction is zero, decrement when one
// [RQ13] interrupt enable changed by set and clear ops or flags restore
// [RQ14] protected mode checks privilege on every interrupt enable change
// [RQ15] trap flag changes only by flags restore; traps after following instruction
// [RQ16] trap entry saves image with trap set and clears live trap flag
// [RQ17] no privilege restriction on trap flag in protected mode
// [RQ18] direction flag set by ops or restore, never privilege checked
// [RQ19] privilege level and nested task writes checked in protected mode
// [RQ20] decoder needs opcode only; other instruction elements are optional
// [RQ21] two explicit operands: at most one memory, except string and stack
// [RQ22] zero, one or two operands, located by eight addressing modes
// [RQ23] status word is 16 bits; reserved positions read a fixed value
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH
// register byte offsets
`define SFC_FLAGS_OFS 8'h00
`define SFC_OPA_OFS 8'h04
`define SFC_OPB_OFS 8'h08
`define SFC_CMD_OFS 8'h0c
`define SFC_RES_OFS 8'h10
`define SFC_IP_OFS 8'h14
`define SFC_CS_OFS 8'h18
`define SFC_PC_OFS 8'h1c
`define SFC_MODE_OFS 8'h20
`define SFC_INDEX_OFS 8'h24
`define SFC_DEC_OFS 8'h28
`define SFC_STAT_OFS 8'h2c
`define SFC_SAVED_OFS 8'h30
// flag positions in the status word
`define SFC_CF_BIT 0
`define SFC_PF_BIT 2
`define SFC_AF_BIT 4
`define SFC_ZF_BIT 6
`define SFC_SF_BIT 7
`define SFC_TF_BIT 8
`define SFC_IF_BIT 9
`define SFC_DF_BIT 10
`define SFC_OF_BIT 11
`define SFC_IO_PRIVILEGE_LEVEL_LSB 12
`define SFC_NT_BIT 14
// fixed value of reserved positions
`define SFC_FLAGS_RSVD 16'h0002
// command fields
`define SFC_CMD_BYTE_BIT 5
`define SFC_CMD_LEN_LSB 8
// op codes
`define SFC_OP_ADD 5'h00
`define SFC_OP_ADC 5'h01
`define SFC_OP_SUB 5'h02
`define SFC_OP_SBB 5'h03
`define SFC_OP_AND 5'h04
`define SFC_OP_OR 5'h05
`define SFC_OP_XOR 5'h06
`define SFC_OP_SHL 5'h07
`define SFC_OP_SHR 5'h08
`define SFC_OP_CLC 5'h09
`define SFC_OP_STC 5'h0a
`define SFC_OP_CMC 5'h0b
`define SFC_OP_STI 5'h0c
`define SFC_OP_CLI 5'h0d
`define SFC_OP_STD 5'h0e
`define SFC_OP_CLD 5'h0f
`define SFC_OP_STR 5'h10
`define SFC_OP_JMP 5'h11
`define SFC_OP_NEXT 5'h12
// operand kinds in the decode descriptor
`define SFC_KIND_REG 2'h0
`define SFC_KIND_MEM 2'h1
`define SFC_KIND_IMM 2'h2
// axi responses
`define SFC_RESP_OKAY 2'h0
`define SFC_RESP_SLVERR 2'h2
`endif

// ==== logic/sfc_flags.v ====
// Purpose: status and control word, alu flag logic, program counter
// Assumes: axi4-lite slave on aclk, synchronous active-low reset
// Notes: a flags register write acts as a restore of a stacked image
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sfc_defines.vh"
module sfc_flags (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// core side
	input wire ext_irq,
	output reg irq_ack,
	output reg step_trap,
	output reg irq_enable
);

	// merge a 16-bit register with the low write lanes
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] nw;
		input [3:0] strb;
		begin
			merge16 = old;
			if (strb[0])
				merge16[7:0] = nw[7:0];
			if (strb[1])
				merge16[15:8] = nw[15:8];
		end
	endfunction

	// top bit of a result at byte or word width
	function top_bit;
		input [15:0] v;
		input is_byte;
		begin
			top_bit = is_byte ? v[7] : v[15];
		end
	endfunction

	// axi handshake state
	reg aw_hold_q;
	reg w_hold_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	// flag state
	reg carry_flag;
	reg parity_flag;
	reg aux_carry_flag;
	reg zero_flag;
	reg sign_flag;
	reg overflow_flag;
	reg trap_flag;
	reg direction_flag;
	reg [1:0] io_privilege_level;
	reg nested_task;
	// datapath state
	reg [15:0] opa_q;
	reg [15:0] opb_q;
	reg [15:0] res_q;
	reg [15:0] instruction_pointer;
	reg [15:0] code_sel_q;
	reg [15:0] dest_index_reg;
	reg prot_mode_q;
	reg [1:0] cpl_q;
	reg [15:0] dec_q;
	reg [15:0] saved_q;
	reg prot_fault_q;
	reg irq_s1_q;
	reg irq_s2_q;
	// decode results read by the handshake process
	reg wr_ok;
	reg [31:0] rd_word;
	reg rd_ok;

	wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	wire [4:0] cmd_op = w_data_q[4:0];
	wire cmd_byte = w_data_q[`SFC_CMD_BYTE_BIT];
	wire [3:0] cmd_len = w_data_q[`SFC_CMD_LEN_LSB+3:`SFC_CMD_LEN_LSB];
	wire cmd_go = wr_go & (aw_addr_q == `SFC_CMD_OFS) & w_strb_q[0];
	wire flags_go = wr_go & (aw_addr_q == `SFC_FLAGS_OFS);

	// privilege tests; real mode lets everything through
	wire may_chg_if = ~prot_mode_q | (cpl_q <= io_privilege_level); // RQ14
	wire may_chg_sys = ~prot_mode_q | (cpl_q == 2'h0); // RQ19

	// assembled status word, reserved positions fixed
	reg [15:0] flags_word;
	always @*
	begin
		flags_word = `SFC_FLAGS_RSVD; // RQ23
		flags_word[`SFC_CF_BIT] = carry_flag; // RQ2
		flags_word[`SFC_PF_BIT] = parity_flag;
		flags_word[`SFC_AF_BIT] = aux_carry_flag;
		flags_word[`SFC_ZF_BIT] = zero_flag;
		flags_word[`SFC_SF_BIT] = sign_flag;
		flags_word[`SFC_TF_BIT] = trap_flag;
		flags_word[`SFC_IF_BIT] = irq_enable;
		flags_word[`SFC_DF_BIT] = direction_flag;
		flags_word[`SFC_OF_BIT] = overflow_flag;
		flags_word[`SFC_IO_PRIVILEGE_LEVEL_LSB+1:`SFC_IO_PRIVILEGE_LEVEL_LSB] = io_privilege_level;
		flags_word[`SFC_NT_BIT] = nested_task;
	end

	// alu: result, carry, overflow and aux carry of the pending command
	reg [16:0] wide;
	reg [15:0] alu_res;
	reg alu_cf;
	reg alu_of;
	reg alu_af;
	reg alu_arith;
	reg alu_logic;
	reg alu_shift;
	reg [15:0] opa_m;
	reg [15:0] opb_m;
	always @*
	begin
		wide = 17'h00000;
		alu_res = 16'h0000;
		alu_cf = carry_flag;
		alu_of = overflow_flag;
		alu_af = aux_carry_flag;
		alu_arith = 1'b0;
		alu_logic = 1'b0;
		alu_shift = 1'b0;
		// byte operands live in the low lane
		opa_m = cmd_byte ? {8'h00, opa_q[7:0]} : opa_q;
		opb_m = cmd_byte ? {8'h00, opb_q[7:0]} : opb_q;
		case (cmd_op)
		`SFC_OP_ADD, `SFC_OP_ADC:
		begin
			wide = {1'b0, opa_m} + {1'b0, opb_m}
				+ {16'h0000, (cmd_op == `SFC_OP_ADC) & carry_flag};
			alu_arith = 1'b1;
		end
		`SFC_OP_SUB, `SFC_OP_SBB:
		begin
			wide = {1'b0, opa_m} - {1'b0, opb_m}
				- {16'h0000, (cmd_op == `SFC_OP_SBB) & carry_flag};
			alu_arith = 1'b1;
		end
		`SFC_OP_AND:
		begin
			wide = {1'b0, opa_m & opb_m};
			alu_logic = 1'b1;
		end
		`SFC_OP_OR:
		begin
			wide = {1'b0, opa_m | opb_m};
			alu_logic = 1'b1;
		end
		`SFC_OP_XOR:
		begin
			wide = {1'b0, opa_m ^ opb_m};
			alu_logic = 1'b1;
		end
		`SFC_OP_SHL:
		begin
			wide = {1'b0, opa_m[14:0], 1'b0};
			alu_shift = 1'b1;
		end
		`SFC_OP_SHR:
		begin
			wide = {2'b00, opa_m[15:1]};
			alu_shift = 1'b1;
		end
		default:
		begin
			wide = 17'h00000;
		end
		endcase
		alu_res = cmd_byte ? {8'h00, wide[7:0]} : wide[15:0];
		if (alu_arith)
		begin
			// carry or borrow out of the msb at operand width
			alu_cf = cmd_byte ? wide[8] : wide[16]; // RQ4
			// carry into msb differs from carry out
			alu_of = top_bit(opa_m ^ opb_m ^ alu_res, cmd_byte)
				^ alu_cf; // RQ7
			alu_af = opa_m[4] ^ opb_m[4] ^ alu_res[4]; // RQ9
		end
		else if (alu_logic)
		begin
			alu_cf = 1'b0;
			alu_of = 1'b0;
		end
		else if (alu_shift)
		begin
			// bit shifted out lands in carry
			alu_cf = (cmd_op == `SFC_OP_SHL) ? top_bit(opa_m, cmd_byte)
				: opa_m[0]; // RQ4
			alu_of = top_bit(alu_res, cmd_byte) ^ alu_cf;
		end
	end
	wire alu_op = (cmd_op <= `SFC_OP_SHR);

	// instruction descriptor check: opcode, operand count and kinds
	wire [1:0] dec_cnt = dec_q[6:5];
	wire [1:0] dec_k1 = dec_q[8:7];
	wire [1:0] dec_k2 = dec_q[10:9];
	wire dec_strstk = dec_q[11];
	wire dec_two_mem = (dec_k1 == `SFC_KIND_MEM) & (dec_k2 == `SFC_KIND_MEM);
	// optional elements bits 4:1 never make a descriptor invalid
	wire dec_valid = dec_q[0] // RQ20
		& (dec_cnt != 2'h3) // RQ22
		& ~((dec_cnt == 2'h2) & dec_two_mem & ~dec_strstk); // RQ21

	// axi handshakes; address and data are taken in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SFC_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `SFC_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awready && s_axi_awvalid)
			begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `SFC_RESP_OKAY : `SFC_RESP_SLVERR;
			end
			// ready comes back only once the response is taken
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? `SFC_RESP_OKAY : `SFC_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// write address decode; read-only registers answer slverr
	always @*
	begin
		case (aw_addr_q)
		`SFC_FLAGS_OFS, `SFC_OPA_OFS, `SFC_OPB_OFS, `SFC_CMD_OFS,
		`SFC_CS_OFS, `SFC_MODE_OFS, `SFC_INDEX_OFS, `SFC_DEC_OFS,
		`SFC_STAT_OFS:
			wr_ok = 1'b1;
		default:
			wr_ok = 1'b0;
		endcase
	end

	// read mux, sampled when the read address is taken
	always @*
	begin
		rd_ok = 1'b1;
		rd_word = 32'h00000000;
		case (s_axi_araddr)
		`SFC_FLAGS_OFS: rd_word = {16'h0000, flags_word};
		`SFC_OPA_OFS: rd_word = {16'h0000, opa_q};
		`SFC_OPB_OFS: rd_word = {16'h0000, opb_q};
		`SFC_CMD_OFS: rd_word = 32'h00000000;
		`SFC_RES_OFS: rd_word = {16'h0000, res_q};
		`SFC_IP_OFS: rd_word = {16'h0000, instruction_pointer};
		`SFC_CS_OFS: rd_word = {16'h0000, code_sel_q};
		`SFC_PC_OFS: rd_word = {code_sel_q, instruction_pointer}; // RQ1
		`SFC_MODE_OFS: rd_word = {29'h00000000, cpl_q, prot_mode_q};
		`SFC_INDEX_OFS: rd_word = {16'h0000, dest_index_reg};
		`SFC_DEC_OFS: rd_word = {16'h0000, dec_q};
		`SFC_STAT_OFS: rd_word = {30'h00000000, dec_valid, prot_fault_q};
		`SFC_SAVED_OFS: rd_word = {16'h0000, saved_q};
		default: rd_ok = 1'b0;
		endcase
	end

	// interrupt request pin passes two flops first
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
		end
		else
		begin
			irq_s1_q <= ext_irq;
			irq_s2_q <= irq_s1_q;
		end
	end

	// flag, pointer and datapath state
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			carry_flag <= 1'b0;
			parity_flag <= 1'b0;
			aux_carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			sign_flag <= 1'b0;
			overflow_flag <= 1'b0;
			trap_flag <= 1'b0;
			irq_enable <= 1'b0;
			direction_flag <= 1'b0;
			io_privilege_level <= 2'h0;
			nested_task <= 1'b0;
			opa_q <= 16'h0000;
			opb_q <= 16'h0000;
			res_q <= 16'h0000;
			instruction_pointer <= 16'h0000;
			code_sel_q <= 16'h0000;
			dest_index_reg <= 16'h0000;
			prot_mode_q <= 1'b0;
			cpl_q <= 2'h0;
			dec_q <= 16'h0000;
			saved_q <= 16'h0000;
			prot_fault_q <= 1'b0;
			irq_ack <= 1'b0;
			step_trap <= 1'b0;
		end
		else
		begin
			irq_ack <= 1'b0;
			step_trap <= 1'b0;
			// plain register writes
			if (wr_go)
			begin
				case (aw_addr_q)
				`SFC_OPA_OFS: opa_q <= merge16(opa_q, w_data_q, w_strb_q);
				`SFC_OPB_OFS: opb_q <= merge16(opb_q, w_data_q, w_strb_q);
				`SFC_CS_OFS:
					code_sel_q <= merge16(code_sel_q, w_data_q, w_strb_q);
				`SFC_INDEX_OFS:
					dest_index_reg <= merge16(dest_index_reg, w_data_q,
						w_strb_q);
				`SFC_DEC_OFS: dec_q <= merge16(dec_q, w_data_q, w_strb_q);
				`SFC_MODE_OFS:
				begin
					if (w_strb_q[0])
					begin
						prot_mode_q <= w_data_q[0];
						cpl_q <= w_data_q[2:1];
					end
				end
				`SFC_STAT_OFS:
				begin
					if (w_strb_q[0] && w_data_q[0])
						prot_fault_q <= 1'b0;
				end
				default:
				begin
				end
				endcase
			end
			// restore of a stacked flags image, field by field
			if (flags_go && w_strb_q[0])
			begin
				carry_flag <= w_data_q[`SFC_CF_BIT];
				parity_flag <= w_data_q[`SFC_PF_BIT];
				aux_carry_flag <= w_data_q[`SFC_AF_BIT];
				zero_flag <= w_data_q[`SFC_ZF_BIT];
				sign_flag <= w_data_q[`SFC_SF_BIT];
			end
			if (flags_go && w_strb_q[1])
			begin
				trap_flag <= w_data_q[`SFC_TF_BIT]; // RQ15 RQ17
				direction_flag <= w_data_q[`SFC_DF_BIT]; // RQ18
				overflow_flag <= w_data_q[`SFC_OF_BIT];
				// unprivileged restore leaves interrupt state alone
				if (may_chg_if)
					irq_enable <= w_data_q[`SFC_IF_BIT]; // RQ13 RQ14
				if (may_chg_sys)
				begin
					io_privilege_level <=
						w_data_q[`SFC_IO_PRIVILEGE_LEVEL_LSB+1:`SFC_IO_PRIVILEGE_LEVEL_LSB]; // RQ19
					nested_task <= w_data_q[`SFC_NT_BIT]; // RQ19
				end
			end
			// commands
			if (cmd_go)
			begin
				if (alu_op)
				begin
					res_q <= alu_res;
					carry_flag <= alu_cf;
					overflow_flag <= alu_of;
					aux_carry_flag <= alu_af;
					zero_flag <= (alu_res == 16'h0000); // RQ5
					sign_flag <= top_bit(alu_res, cmd_byte); // RQ6
					parity_flag <= ^alu_res[7:0]; // RQ8
				end
				case (cmd_op)
				`SFC_OP_CLC: carry_flag <= 1'b0; // RQ3
				`SFC_OP_STC: carry_flag <= 1'b1; // RQ3
				`SFC_OP_CMC: carry_flag <= ~carry_flag; // RQ3
				`SFC_OP_STI, `SFC_OP_CLI:
				begin
					// a refused change is flagged, not executed
					if (may_chg_if)
						irq_enable <= (cmd_op == `SFC_OP_STI); // RQ13 RQ14
					else
						prot_fault_q <= 1'b1; // RQ14
				end
				`SFC_OP_STD: direction_flag <= 1'b1; // RQ18
				`SFC_OP_CLD: direction_flag <= 1'b0; // RQ18
				`SFC_OP_STR:
				begin
					if (direction_flag)
						dest_index_reg <= dest_index_reg
							- (cmd_byte ? 16'h0001 : 16'h0002); // RQ12
					else
						dest_index_reg <= dest_index_reg
							+ (cmd_byte ? 16'h0001 : 16'h0002); // RQ12
				end
				`SFC_OP_JMP: instruction_pointer <= opa_q; // RQ1
				`SFC_OP_NEXT:
				begin
					// instruction completes: advance to the next one
					instruction_pointer <= instruction_pointer
						+ {12'h000, cmd_len}; // RQ1
					if (trap_flag)
					begin
						// debug trap has priority over the external request
						saved_q <= flags_word; // RQ16
						trap_flag <= 1'b0; // RQ16
						step_trap <= 1'b1; // RQ11
					end
					else if (irq_enable && irq_s2_q)
					begin
						saved_q <= flags_word;
						irq_ack <= 1'b1; // RQ10
					end
				end
				default:
				begin
				end
				endcase
			end
		end
	end

endmodule

// ==== tb/sfc_flags_checker.sv ====
// Purpose: bus and core pulse timing checks on the flags block ports
// Assumes: single clock domain, synchronous active-low reset
// Notes: bound to every instance of sfc_flags
`timescale 1ns/1ps
module sfc_flags_checker (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// write side handshakes
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	// read side handshakes
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// core pulses and level
	input wire irq_ack,
	input wire step_trap,
	input wire irq_enable
);
	// one domain, so clock and disable are shared
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_B_AFTER_AW: assert property
		($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
		else $error("write answered before address and data taken");
	AST_B_HOLD: assert property
		(s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed");
	AST_B_DONE: assert property
		(s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write channel not reopened");
	AST_R_ANSWER: assert property
		(s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered one cycle later");
	AST_R_HOLD: assert property
		(s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped or changed");
	AST_ACK_NEEDS_IE: assert property (irq_ack |-> irq_enable)
		else $error("interrupt taken while disabled");
	AST_TRAP_PULSE: assert property (step_trap |=> !step_trap)
		else $error("trap pulse longer than one cycle");
	AST_PULSE_AT_WRITE: assert property
		(irq_ack || step_trap |-> $rose(s_axi_bvalid))
		else $error("core pulse not at command completion");
	AST_TRAP_FIRST: assert property (!(irq_ack && step_trap))
		else $error("trap and interrupt taken together");
	AST_IE_BY_WRITE: assert property
		($changed(irq_enable) |-> $rose(s_axi_bvalid))
		else $error("interrupt enable moved without a write");
endmodule

bind sfc_flags sfc_flags_checker u_checker (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq_ack,
	.step_trap, .irq_enable);

// ==== tb/sfc_core_model.sv ====
// Purpose: interrupt source and pulse tally standing for the core
// Assumes: runs on the block clock
// Notes: request line held until the block accepts it
`timescale 1ns/1ps
module sfc_core_model (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// bench control and block pulses
	input wire raise,
	input wire irq_ack,
	input wire step_trap,
	// request and tallies
	output logic ext_irq = 1'b0,
	output int acks,
	output int traps
);
	// a real source keeps asking until served, so drop only on ack
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_irq <= 1'b0;
			acks <= 0;
			traps <= 0;
		end
		else
		begin
			if (irq_ack)
				ext_irq <= 1'b0;
			else if (raise)
				ext_irq <= 1'b1;
			acks <= acks + irq_ack;
			traps <= traps + step_trap;
		end
	end
endmodule

// ==== tb/cpu_flags_status_control_tb.sv ====
// Purpose: self-checking bench of the flags block over its register bus
// Assumes: 100 ns clock, reset low for two cycles
// Notes: expected flags come from a bench model kept in ef
`timescale 1ns/1ps
`include "sfc_defines.vh"
module cpu_flags_status_control_tb;
	logic aclk, aresetn, ext_irq, irq_ack, step_trap, irq_enable, raise;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, byt, afk;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] ef, ea, eb, res;
	logic [4:0] op;
	logic [15:0] dtab [7] = '{16'h80c1, 16'h02c1, 16'h8ac1, 16'h0061,
		16'h0000, 16'h8001, 16'h8421};
	int errors, checked, acks, traps;

	sfc_flags DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq, .irq_ack,
		.step_trap, .irq_enable);
	sfc_core_model u_core (.aclk, .aresetn, .raise, .irq_ack, .step_trap,
		.ext_irq, .acks, .traps);

	// free-running clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic report_and_stop;
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input [31:0] e, input [31:0] s);
		checked++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	// one clock with a bound, so a dead handshake ends the run
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 60)
		begin
			errors++;
			report_and_stop;
		end
	endtask

	// ready is raised only after valid shows, to exercise the hold
	task automatic wr(input [7:0] ad, input [31:0] d,
		input [1:0] er = `SFC_RESP_OKAY);
		int n;
		n = 0;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		tick(n);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask

	task automatic rchk(input string nm, input [7:0] ad, input [31:0] m,
		input [31:0] e, input [1:0] er = `SFC_RESP_OKAY);
		int n;
		n = 0;
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		tick(n);
		s_axi_rready <= 1'b0;
		chk(nm, e & m, s_axi_rdata & m);
		chk("rresp", er, s_axi_rresp);
	endtask

	task automatic cmd(input [4:0] c, input b = 1'b0, input [3:0] len = 4'h0);
		wr(`SFC_CMD_OFS, {20'h0, len, 2'b0, b, c});
	endtask

	function automatic [31:0] lfsr(input [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected {result, flags}; shifts leave aux carry open
	function automatic [31:0] alu(input [4:0] c, input [15:0] a,
		input [15:0] b, input bm);
		logic [16:0] r;
		logic [15:0] f, x;
		logic cy, m;
		int w;
		w = bm ? 8 : 16;
		if (bm)
		begin
			a[15:8] = 8'h00;
			b[15:8] = 8'h00;
		end
		f = ef;
		x = (c == `SFC_OP_SUB || c == `SFC_OP_SBB) ? ~b : b;
		case (c)
			`SFC_OP_ADD: r = a + b;
			`SFC_OP_ADC: r = a + b + ef[0];
			`SFC_OP_SUB: r = a - b;
			`SFC_OP_SBB: r = a - b - ef[0];
			`SFC_OP_AND: r = a & b;
			`SFC_OP_OR: r = a | b;
			`SFC_OP_XOR: r = a ^ b;
			`SFC_OP_SHL: r = {a, 1'b0};
			default: r = a >> 1;
		endcase
		cy = (c == `SFC_OP_SHR) ? a[0] : r[w];
		r = bm ? {9'h0, r[7:0]} : {1'b0, r[15:0]};
		m = r[w-1];
		f[`SFC_OF_BIT] = (c >= `SFC_OP_SHL) && (m ^ cy);
		if (c <= `SFC_OP_SBB)
		begin
			f[`SFC_OF_BIT] = (a[w-1] == x[w-1]) && (m != a[w-1]);
			f[`SFC_AF_BIT] = a[4] ^ b[4] ^ r[4];
		end
		f[`SFC_CF_BIT] = (c <= `SFC_OP_SBB || c >= `SFC_OP_SHL) && cy;
		f[`SFC_ZF_BIT] = (r == 17'h0);
		f[`SFC_SF_BIT] = m;
		f[`SFC_PF_BIT] = ^r[7:0];
		return {r[15:0], f};
	endfunction

	initial
	begin
		{aresetn, raise, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		seed = 32'hbc7bae99;
		ef = 16'h0002;
		afk = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("flags", `SFC_FLAGS_OFS, 32'hffffffff, 32'h0002);
		chk("ie", 1'b0, irq_enable);
		// corner operands first, then random ones through every alu op
		for (int i = 0; i < 45; i++)
		begin
			seed = lfsr(seed);
			{eb, ea} = seed;
			case (i)
				0: {eb, ea} = 32'h0001_7fff;
				1: {eb, ea} = 32'h0001_000f;
				2: {eb, ea} = 32'h0001_0000;
				3: {eb, ea} = 32'h0080_0080;
			endcase
			op = i % 9;
			byt = (i == 3) || (i > 3 && seed[20]);
			wr(`SFC_OPA_OFS, {16'h0, ea});
			wr(`SFC_OPB_OFS, {16'h0, eb});
			cmd(op, byt);
			{res, ef} = alu(op, ea, eb, byt);
			afk = (op >= `SFC_OP_SHL) || (afk && op > `SFC_OP_SBB);
			rchk("result", `SFC_RES_OFS, 32'hffff, {16'h0, res});
			rchk("flags", `SFC_FLAGS_OFS, afk ? 32'hffef : 32'hffff, {16'h0, ef});
		end
		// clear, set, then invert twice
		for (int i = 0; i < 4; i++)
		begin
			op = (i < 2) ? `SFC_OP_CLC + i : `SFC_OP_CMC;
			cmd(op);
			ef[0] = (op == `SFC_OP_CMC) ? ~ef[0] : (op == `SFC_OP_STC);
			rchk("carry", `SFC_FLAGS_OFS, 32'h1, {16'h0, ef});
		end
		wr(`SFC_INDEX_OFS, 32'h0100);
		cmd(`SFC_OP_STD);
		cmd(`SFC_OP_STR);
		rchk("index", `SFC_INDEX_OFS, 32'hffff, 32'h00fe);
		cmd(`SFC_OP_CLD);
		cmd(`SFC_OP_STR, 1'b1);
		rchk("index", `SFC_INDEX_OFS, 32'hffff, 32'h00ff);
		wr(`SFC_OPA_OFS, 32'h1234);
		cmd(`SFC_OP_JMP);
		cmd(`SFC_OP_NEXT, 1'b0, 4'h3);
		rchk("ip", `SFC_IP_OFS, 32'hffff, 32'h1237);
		wr(`SFC_CS_OFS, 32'habcd);
		rchk("pc", `SFC_PC_OFS, 32'hffffffff, 32'habcd1237);
		wr(`SFC_IP_OFS, 32'h0, `SFC_RESP_SLVERR);
		// restore with trap set, then step twice; only the first traps
		wr(`SFC_FLAGS_OFS, 32'h0102);
		cmd(`SFC_OP_NEXT, 1'b0, 4'h1);
		chk("traps", 1, traps);
		rchk("saved", `SFC_SAVED_OFS, 32'hffff, 32'h0102);
		rchk("flags", `SFC_FLAGS_OFS, 32'hffff, 32'h0002);
		cmd(`SFC_OP_NEXT, 1'b0, 4'h1);
		chk("traps", 1, traps);
		rchk("ip", `SFC_IP_OFS, 32'hffff, 32'h1239);
		// pending request: taken when enabled, held off when not
		raise <= 1'b1;
		cmd(`SFC_OP_STI);
		chk("ie", 1'b1, irq_enable);
		cmd(`SFC_OP_NEXT);
		chk("acks", 1, acks);
		cmd(`SFC_OP_CLI);
		raise <= 1'b0;
		cmd(`SFC_OP_NEXT);
		chk("acks", 1, acks);
		cmd(`SFC_OP_STI);
		cmd(`SFC_OP_NEXT);
		chk("acks", 2, acks);
		wr(`SFC_FLAGS_OFS, 32'h0002);
		chk("ie", 1'b0, irq_enable);
		wr(`SFC_FLAGS_OFS, 32'h0202);
		chk("ie", 1'b1, irq_enable);
		// protected mode at the least privileged level
		wr(`SFC_MODE_OFS, 32'h7);
		cmd(`SFC_OP_CLI);
		chk("ie", 1'b1, irq_enable);
		rchk("fault", `SFC_STAT_OFS, 32'h1, 32'h1);
		wr(`SFC_STAT_OFS, 32'h1);
		rchk("fault", `SFC_STAT_OFS, 32'h1, 32'h0);
		wr(`SFC_FLAGS_OFS, 32'h3502);
		chk("ie", 1'b1, irq_enable);
		cmd(`SFC_OP_NEXT);
		chk("traps", 2, traps);
		rchk("flags", `SFC_FLAGS_OFS, 32'hffff, 32'h0602);
		foreach (dtab[i])
		begin
			wr(`SFC_DEC_OFS, {17'h0, dtab[i][14:0]});
			rchk("decode", `SFC_STAT_OFS, 32'h2, {30'h0, dtab[i][15], 1'b0});
		end
		rchk("unmapped", 8'h40, 32'hffffffff, 32'h0, `SFC_RESP_SLVERR);
		wr(8'h40, 32'h1, `SFC_RESP_SLVERR);
		report_and_stop;
	end
endmodule
